// >>> rtl/haptic_i2c_slave_interface.v
`timescale 1ns/10ps
`default_nettype none
`include "haptic_i2c_consts.vh"

// How it works
// R01: Base slave address is a 7-bit register field, resetting to 0x4A.
// R02: Effective address is base with its two low bits taken from address pins.
// R03: Address pins are read live; a pin change moves the effective address.
// R04: Host waits 50 us after changing address pins before addressing device.
// R05: Bus clock up to 1 MHz is followed; clock line is never stretched.
// R06: Device is slave only and never starts a transfer.
// R07: Address and data move as eight-bit groups, most significant bit first.
// R08: While enabled, device acknowledges its own address in the next clock.
// R09: Write is start, address, register, data, stop; every byte acknowledged.
// R10: Read writes register pointer, restarts with read bit, ends in NAK and stop.
// R11: Write-mode 0: master ACK after a read byte advances pointer without limit.
// R12: Reading a register that does not exist returns zero.
// R13: In page mode host reuses the same slave address after repeated start.
// R14: Write-mode 0: further data bytes go to incremented addresses, all acked.
// R15: Write-mode 1: register/data pairs repeat; each data uses preceding address.
// R16: Write-mode 1: stop inside a message returns to idle; start restarts the address phase.
// R17: Mode 0 allows incrementing and plain access; mode 1 only non-incrementing.
// R18: Bus lines are only pulled low, never driven high.
// R19: On address mismatch the data line stays released for the whole transfer.
module haptic_i2c_slave_interface (
    input wire clk_i,
    input wire rst_i,
    input wire if_enable_i,
    input wire scl_i,
    output wire scl_o,
    output wire scl_oe_o,
    input wire sda_i,
    output wire sda_o,
    output reg sda_oe_o,
    input wire addr_sel_1_i,
    input wire addr_sel_0_i,
    output reg reg_wr_o,
    output reg [7:0] reg_waddr_o,
    output reg [7:0] reg_wdata_o,
    output reg reg_rd_o,
    output reg [7:0] reg_raddr_o,
    input wire [7:0] reg_rdata_i,
    input wire reg_hit_i,
    output wire wr_mode_o,
    output wire timeout_en_o
);
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_RX = 3'd1;
    localparam [2:0] ST_ACK = 3'd2;
    localparam [2:0] ST_TX = 3'd3;
    localparam [2:0] ST_RACK = 3'd4;
    localparam [2:0] ST_IGNORE = 3'd5;

    localparam [1:0] RX_SLAVE = 2'd0;
    localparam [1:0] RX_REG = 2'd1;
    localparam [1:0] RX_DATA = 2'd2;

    // Mode register reset value, split into its two stored bits at reset
    localparam [7:0] MODE_RESET = `MODE_REG_RESET;

    wire scl_s;
    wire scl_p;
    wire sda_s;
    wire sda_p;
    wire [1:0] pins_s;

    // Mode register: only bits 7 and 6 are stored, the rest read as zero
    reg wr_mode;
    reg to_enable;
    reg [6:0] base_addr;

    reg [2:0] state;
    reg [1:0] rx_kind;
    reg [1:0] next_kind;
    reg next_is_tx;
    reg [2:0] bit_cnt;
    reg [7:0] shift;
    reg got_byte;
    reg [7:0] pointer;
    reg [7:0] tx;
    reg rack_ok;

    wire scl_rise;
    wire scl_fall;
    wire start_cond;
    wire stop_cond;
    wire [6:0] eff_addr;
    wire [7:0] rd_value;

    i2c_line_sync #(.W(2), .INIT(2'b11)) u_bus_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({scl_i, sda_i}),
        .q_o({scl_s, sda_s}),
        .q_prev_o({scl_p, sda_p})
    );

    i2c_line_sync #(.W(2), .INIT(2'b00)) u_pin_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({addr_sel_1_i, addr_sel_0_i}),
        .q_o(pins_s),
        .q_prev_o()
    );

    assign scl_rise = scl_s & ~scl_p;
    assign scl_fall = ~scl_s & scl_p;
    assign start_cond = scl_s & scl_p & sda_p & ~sda_s;
    assign stop_cond = scl_s & scl_p & ~sda_p & sda_s;

    // Pins are resampled every cycle through two sync stages, so a change takes effect two clocks later
    assign eff_addr = {base_addr[6:2], pins_s}; // R02 R03

    // The clock line is never pulled: no stretching, no arbitration
    assign scl_o = 1'b0; // R05 R18
    assign scl_oe_o = 1'b0; // R05 R06

    // Data line is only ever pulled low; enable alone decides the level
    assign sda_o = 1'b0; // R18

    assign wr_mode_o = wr_mode;
    assign timeout_en_o = to_enable;

    // Registers 0x08 and 0x09 live here; writes to them never reach the external port
    function is_mode_reg;
        input [7:0] addr;
        begin
            is_mode_reg = (addr == `MODE_REG_ADDR);
        end
    endfunction

    function is_base_reg;
        input [7:0] addr;
        begin
            is_base_reg = (addr == `ADDR_REG_ADDR);
        end
    endfunction

    // Pointer wraps at eight bits on both the write and the read path
    function [7:0] step_pointer;
        input [7:0] addr;
        begin
            step_pointer = addr + 8'h01;
        end
    endfunction

    // Open drain: a one is sent by letting go of the line, a zero by pulling
    function pull_for;
        input level;
        begin
            pull_for = ~level;
        end
    endfunction

    function [7:0] read_value;
        input [7:0] addr;
        input [7:0] ext_data;
        input ext_hit;
        input mode_bit;
        input to_bit;
        input [6:0] base;
        begin
            if (is_mode_reg(addr)) begin
                read_value = {mode_bit, to_bit, 6'h00};
            end else if (is_base_reg(addr)) begin
                read_value = {1'b0, base};
            end else if (ext_hit) begin
                read_value = ext_data;
            end else begin
                read_value = 8'h00; // R12
            end
        end
    endfunction

    assign rd_value = read_value(pointer, reg_rdata_i, reg_hit_i, wr_mode, to_enable, base_addr);

    always @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
            rx_kind <= RX_SLAVE;
            next_kind <= RX_SLAVE;
            next_is_tx <= 1'b0;
            bit_cnt <= 3'd0;
            shift <= 8'h00;
            got_byte <= 1'b0;
            pointer <= 8'h00;
            tx <= 8'h00;
            rack_ok <= 1'b0;
            sda_oe_o <= 1'b0;
            // Stored mode bits come from the mode register's reset value
            wr_mode <= MODE_RESET[`WR_MODE_BIT];
            to_enable <= MODE_RESET[`TO_ENABLE_BIT];
            base_addr <= `BASE_ADDR_RESET; // R01
            reg_wr_o <= 1'b0;
            reg_waddr_o <= 8'h00;
            reg_wdata_o <= 8'h00;
            reg_rd_o <= 1'b0;
            reg_raddr_o <= 8'h00;
        end else begin
            reg_wr_o <= 1'b0;
            reg_rd_o <= 1'b0;
            // External port follows the pointer one clock behind; reads settle before use
            reg_raddr_o <= pointer;
            if (!if_enable_i) begin
                // Disabled interface watches nothing and lets go of the bus
                state <= ST_IDLE;
                sda_oe_o <= 1'b0;
            end else if (start_cond) begin
                // Start and repeated start both begin a new address phase
                state <= ST_RX; // R16
                rx_kind <= RX_SLAVE;
                bit_cnt <= 3'd0;
                got_byte <= 1'b0;
                sda_oe_o <= 1'b0;
            end else if (stop_cond) begin
                state <= ST_IDLE; // R16
                sda_oe_o <= 1'b0;
            end else begin
                case (state)
                    ST_IDLE: begin
                        sda_oe_o <= 1'b0;
                    end
                    ST_RX: begin
                        if (scl_rise) begin
                            shift <= {shift[6:0], sda_s}; // R07
                            bit_cnt <= bit_cnt + 3'd1;
                            if (bit_cnt == 3'd7) begin
                                got_byte <= 1'b1;
                            end
                        end else if (scl_fall && got_byte) begin
                            got_byte <= 1'b0;
                            bit_cnt <= 3'd0;
                            case (rx_kind)
                                RX_SLAVE: begin
                                    if (shift[7:1] == eff_addr) begin
                                        sda_oe_o <= 1'b1; // R08
                                        state <= ST_ACK;
                                        next_is_tx <= shift[0];
                                        next_kind <= RX_REG;
                                    end else begin
                                        state <= ST_IGNORE; // R19
                                    end
                                end
                                RX_REG: begin
                                    pointer <= shift;
                                    sda_oe_o <= 1'b1; // R09
                                    state <= ST_ACK;
                                    next_is_tx <= 1'b0;
                                    next_kind <= RX_DATA;
                                end
                                RX_DATA: begin
                                    sda_oe_o <= 1'b1; // R09
                                    state <= ST_ACK;
                                    next_is_tx <= 1'b0;
                                    if (is_mode_reg(pointer)) begin
                                        wr_mode <= shift[`WR_MODE_BIT];
                                        to_enable <= shift[`TO_ENABLE_BIT];
                                    end else if (is_base_reg(pointer)) begin
                                        base_addr <= shift[6:0]; // R01
                                    end else begin
                                        reg_wr_o <= 1'b1;
                                        reg_waddr_o <= pointer;
                                        reg_wdata_o <= shift;
                                    end
                                    if (wr_mode) begin
                                        // Next byte names a fresh register
                                        next_kind <= RX_REG; // R15 R17
                                    end else begin
                                        pointer <= step_pointer(pointer); // R14
                                        next_kind <= RX_DATA;
                                    end
                                end
                                default: begin
                                    state <= ST_IGNORE;
                                end
                            endcase
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            if (next_is_tx) begin
                                // Read data is fetched at the ack's end, MSB first
                                tx <= rd_value; // R10
                                reg_rd_o <= 1'b1;
                                sda_oe_o <= pull_for(rd_value[7]); // R07
                                bit_cnt <= 3'd1;
                                state <= ST_TX;
                            end else begin
                                sda_oe_o <= 1'b0;
                                rx_kind <= next_kind;
                                bit_cnt <= 3'd0;
                                state <= ST_RX;
                            end
                        end
                    end
                    ST_TX: begin
                        if (scl_fall) begin
                            if (bit_cnt == 3'd0) begin
                                // Eighth bit done: let go so the master can answer
                                sda_oe_o <= 1'b0;
                                rack_ok <= 1'b0;
                                state <= ST_RACK;
                            end else begin
                                sda_oe_o <= pull_for(tx[6]); // R07
                                tx <= {tx[6:0], 1'b0};
                                bit_cnt <= bit_cnt + 3'd1;
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_rise) begin
                            // In write-mode 0 the pointer moves on the master's ack so the fetch at the fall sees it
                            rack_ok <= ~sda_s;
                            if (!sda_s && !wr_mode) begin
                                pointer <= step_pointer(pointer); // R11 R17
                            end
                        end else if (scl_fall) begin
                            if (rack_ok) begin
                                tx <= rd_value; // R11
                                reg_rd_o <= 1'b1;
                                sda_oe_o <= pull_for(rd_value[7]);
                                bit_cnt <= 3'd1;
                                state <= ST_TX;
                            end else begin
                                // NAK ends the read; wait for stop
                                state <= ST_IGNORE; // R10
                            end
                        end
                    end
                    ST_IGNORE: begin
                        // A foreign or finished transfer is sat out until start or stop
                        sda_oe_o <= 1'b0; // R19
                    end
                    default: begin
                        state <= ST_IDLE;
                        sda_oe_o <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule

`default_nettype wire

// >>> rtl/haptic_i2c_consts.vh
`ifndef HAPTIC_I2C_CONSTS_VH
`define HAPTIC_I2C_CONSTS_VH

// Register indices held inside the interface
`define MODE_REG_ADDR 8'h08
`define ADDR_REG_ADDR 8'h09

// Reset values
`define MODE_REG_RESET 8'h40
`define BASE_ADDR_RESET 7'h4A

// Field positions in the mode register
`define WR_MODE_BIT 7
`define TO_ENABLE_BIT 6

// Host settle time after address-pin change, and its count at 50 MHz
`define CLK_PERIOD_NS 20
`define ADDR_SETTLE_US 50
`define ADDR_SETTLE_CYCLES ((`ADDR_SETTLE_US * 1000) / `CLK_PERIOD_NS)

`endif

// >>> rtl/i2c_line_sync.v
`timescale 1ns/10ps
`default_nettype none

// Two-stage synchroniser with one extra stage for edge detection
module i2c_line_sync #(
    parameter W = 1,
    parameter [W-1:0] INIT = {W{1'b1}}
) (
    input wire clk_i,
    input wire rst_i,
    input wire [W-1:0] d_i,
    output reg [W-1:0] q_o,
    output reg [W-1:0] q_prev_o
);
    reg [W-1:0] meta;

    always @(posedge clk_i) begin
        if (rst_i) begin
            meta <= INIT;
            q_o <= INIT;
            q_prev_o <= INIT;
        end else begin
            meta <= d_i;
            q_o <= meta;
            q_prev_o <= q_o;
        end
    end
endmodule

`default_nettype wire

// >>> bench/haptic_i2c_slave_interface_properties.sv
`timescale 1ns/10ps
`default_nettype none
module i2c_slave_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic if_enable_i,
    input wire logic scl_i,
    input wire logic scl_o,
    input wire logic scl_oe_o,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic reg_wr_o,
    input wire logic [7:0] reg_waddr_o,
    input wire logic reg_rd_o,
    input wire logic wr_mode_o,
    input wire logic timeout_en_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_acked;
        ##[0:2] sda_oe_o;
    endsequence
    sequence s_one_cycle(sig);
        ##1 !sig;
    endsequence
    property p_no_stretch; scl_oe_o == 1'b0; endproperty
    a_no_stretch: assert property (p_no_stretch) else $error("clock line pulled");
    property p_low_only; sda_oe_o |-> (sda_o == 1'b0 && scl_o == 1'b0); endproperty
    a_low_only: assert property (p_low_only) else $error("line driven high");
    property p_silent; !if_enable_i [*2] |-> !sda_oe_o; endproperty
    a_silent: assert property (p_silent) else $error("drive while disabled");
    property p_wr_pulse; reg_wr_o |-> s_one_cycle(reg_wr_o); endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
    property p_rd_pulse; reg_rd_o |-> s_one_cycle(reg_rd_o); endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe too long");
    property p_wr_acked; reg_wr_o |-> s_acked; endproperty
    a_wr_acked: assert property (p_wr_acked) else $error("data byte not acked");
    property p_wr_external;
        reg_wr_o |-> (reg_waddr_o != 8'h08 && reg_waddr_o != 8'h09);
    endproperty
    a_wr_external: assert property (p_wr_external) else $error("internal reg forwarded");
    // Data may only move while the clock line is low, else it reads as start or stop
    property p_change_scl_low; $changed(sda_oe_o) |-> !$past(scl_i, 2); endproperty
    a_change_scl_low: assert property (p_change_scl_low) else $error("data moved, clock high");
    property p_reset_vals; $fell(rst_i) |-> (!wr_mode_o && timeout_en_o && !sda_oe_o); endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad reset state");
endmodule
bind haptic_i2c_slave_interface i2c_slave_checker chk (.clk_i(clk_i), .rst_i(rst_i),
    .if_enable_i(if_enable_i), .scl_i(scl_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .reg_wr_o(reg_wr_o),
    .reg_waddr_o(reg_waddr_o), .reg_rd_o(reg_rd_o), .wr_mode_o(wr_mode_o),
    .timeout_en_o(timeout_en_o));
`default_nettype wire

// >>> bench/i2c_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module i2c_host_model (
    input wire logic clk_i,
    output logic scl_pull_o,
    output logic sda_pull_o,
    input wire logic sda_i
);
    initial begin
        scl_pull_o = 1'b0;
        sda_pull_o = 1'b0;
    end
    // Lines move on rising edges, one to four clocks apart; one bit lasts 160 ns
    task automatic start();
        @(posedge clk_i) sda_pull_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        scl_pull_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        sda_pull_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        scl_pull_o <= 1'b1;
    endtask
    task automatic stop();
        @(posedge clk_i) sda_pull_o <= 1'b1;
        repeat (3) @(posedge clk_i);
        scl_pull_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        sda_pull_o <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask
    // Data is taken at the edge that drops the clock, while it still stands
    task automatic xfer(input logic [7:0] wb, input logic rd, input logic mack,
                        output logic [7:0] rb, output logic ack);
        for (int i = 0; i < 9; i++) begin
            @(posedge clk_i) sda_pull_o <= (i == 8) ? (rd & mack) : (~rd & ~wb[7]);
            repeat (3) @(posedge clk_i);
            scl_pull_o <= 1'b0;
            repeat (4) @(posedge clk_i);
            if (i == 8) ack = ~sda_i; else rb = {rb[6:0], sda_i};
            wb = wb << 1;
            scl_pull_o <= 1'b1;
        end
    endtask
endmodule
`default_nettype wire

// >>> bench/haptic_i2c_slave_interface_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "haptic_i2c_consts.vh"
module haptic_i2c_slave_interface_bench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic if_enable_i = 1'b1;
    logic [1:0] pins = 2'b00;
    logic scl_pull, sda_pull, ack;
    logic [7:0] rb;
    logic [15:0] wq[$];
    int n_mismatch = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n_fetch = 0;
    wire logic scl_o, scl_oe_o, sda_o, sda_oe_o, reg_wr_o, reg_rd_o, wr_mode_o, timeout_en_o;
    wire logic [7:0] reg_waddr_o, reg_wdata_o, reg_raddr_o;
    wire logic scl_line = ~(scl_pull | scl_oe_o);
    wire logic sda_line = ~(sda_pull | sda_oe_o);
    // Upper half is unpopulated yet answers garbage, so the zero fill shows
    wire logic [7:0] rdata = reg_raddr_o ^ 8'h5A;
    wire logic hit = ~reg_raddr_o[7];
    always #10 clk_i = ~clk_i;
    haptic_i2c_slave_interface dut (.clk_i(clk_i), .rst_i(rst_i), .if_enable_i(if_enable_i),
        .scl_i(scl_line), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_line), .sda_o(sda_o),
        .sda_oe_o(sda_oe_o), .addr_sel_1_i(pins[1]), .addr_sel_0_i(pins[0]),
        .reg_wr_o(reg_wr_o), .reg_waddr_o(reg_waddr_o), .reg_wdata_o(reg_wdata_o),
        .reg_rd_o(reg_rd_o), .reg_raddr_o(reg_raddr_o), .reg_rdata_i(rdata),
        .reg_hit_i(hit), .wr_mode_o(wr_mode_o), .timeout_en_o(timeout_en_o));
    i2c_host_model host (.clk_i(clk_i), .scl_pull_o(scl_pull), .sda_pull_o(sda_pull),
        .sda_i(sda_line));
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (reg_wr_o === 1'b1) wq.push_back({reg_waddr_o, reg_wdata_o});
        if (reg_rd_o === 1'b1) n_fetch <= n_fetch + 1;
        if (cycles == 40000) begin
            n_mismatch++;
            complete_run();
        end
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] b, input logic exp_ack);
        host.xfer(b, 1'b0, 1'b0, rb, ack);
        check("ack", {15'h0, ack}, {15'h0, exp_ack});
    endtask
    task automatic write_regs(input logic [6:0] sa, input logic [7:0] bytes[$]);
        host.start();
        wr({sa, 1'b0}, 1'b1);
        foreach (bytes[k]) wr(bytes[k], 1'b1);
        host.stop();
    endtask
    task automatic read_regs(input logic [6:0] sa, input logic [7:0] ra, input logic [7:0] exp[$]);
        int f0;
        f0 = n_fetch;
        host.start();
        wr({sa, 1'b0}, 1'b1);
        wr(ra, 1'b1);
        host.start();
        wr({sa, 1'b1}, 1'b1);
        foreach (exp[k]) begin
            host.xfer(8'hFF, 1'b1, k < exp.size() - 1, rb, ack);
            check("rdata", {8'h0, rb}, {8'h0, exp[k]});
        end
        host.stop();
        check("fetches", 16'(n_fetch - f0), 16'(exp.size()));
    endtask
    task automatic expect_wr(input logic [15:0] exp[$]);
        check("writes", 16'(wq.size()), 16'(exp.size()));
        foreach (exp[k]) if (k < wq.size()) check("write", wq[k], exp[k]);
        wq.delete();
    endtask
    task automatic t_pins();
        for (int p = 0; p < 4; p++) begin
            @(posedge clk_i);
            pins <= 2'(p);
            repeat (`ADDR_SETTLE_CYCLES) @(posedge clk_i);
            host.start();
            wr({5'b10010, 2'(p) ^ 2'b01, 1'b0}, 1'b0);
            host.stop();
            write_regs({5'b10010, 2'(p)}, '{8'h20, 8'(p)});
            expect_wr('{{8'h20, 8'(p)}});
        end
    endtask
    task automatic t_page();
        write_regs(7'h4B, '{8'h30, 8'hA1, 8'hA2, 8'hA3});
        expect_wr('{16'h30A1, 16'h31A2, 16'h32A3});
        read_regs(7'h4B, 8'h7E, '{8'h24, 8'h25, 8'h00});
    endtask
    task automatic t_repeat();
        write_regs(7'h4B, '{8'h08, 8'h80});
        check("mode", {15'h0, wr_mode_o}, 16'h0001);
        check("timeout bit", {15'h0, timeout_en_o}, 16'h0000);
        write_regs(7'h4B, '{8'h21, 8'h11, 8'h25, 8'h22});
        expect_wr('{16'h2111, 16'h2522});
        read_regs(7'h4B, 8'h21, '{8'h7B, 8'h7B});
        host.start();
        wr(8'h96, 1'b1);
        wr(8'h26, 1'b1);
        write_regs(7'h4B, '{8'h27, 8'h33});
        expect_wr('{16'h2733});
        write_regs(7'h4B, '{8'h08, 8'h40});
        check("mode back", {14'h0, wr_mode_o, timeout_en_o}, 16'h0001);
    endtask
    task automatic t_base();
        write_regs(7'h4B, '{8'h09, 8'h20});
        host.start();
        wr(8'h96, 1'b0);
        host.stop();
        write_regs(7'h23, '{8'h40, 8'h5C});
        expect_wr('{16'h405C});
        read_regs(7'h23, 8'h09, '{8'h20});
        @(posedge clk_i);
        if_enable_i <= 1'b0;
        host.start();
        wr(8'h46, 1'b0);
        host.stop();
        @(posedge clk_i);
        if_enable_i <= 1'b1;
    endtask
    task automatic complete_run();
        if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        check("reset", {12'h0, wr_mode_o, timeout_en_o, scl_oe_o, sda_oe_o}, 16'h0004);
        t_pins();
        t_page();
        t_repeat();
        t_base();
        complete_run();
    end
endmodule
`default_nettype wire
